/* wcc_cfg.svh */
// constants for the watchdog-clear and complement execution block
// assumes one 25 MHz clock and a four-phase instruction cycle
// Operation
// - clear-watchdog resets the watchdog counter to zero.
// - clear-watchdog also returns the watchdog postscaler to zero.
// - clear-watchdog sets timeout and powerdown flags, no other status bits.
// - complement inverts file register; d=0 to working reg, d=1 back.
// - access bit zero uses access bank, one uses bank select register.
// - extended set, a=0, f at most 5Fh: indexed literal offset addressing.
`ifndef WCC_CFG_SVH
`define WCC_CFG_SVH

// apb byte offsets
`define WCC_OFS_CTRL      12'h000
`define WCC_OFS_BANK      12'h004
`define WCC_OFS_WORK      12'h008
`define WCC_OFS_STATUS    12'h00c
`define WCC_OFS_WATCHDOG  12'h010
`define WCC_OFS_INDEX     12'h014

// control fields
`define WCC_CTRL_EXT      0
`define WCC_CTRL_RUN      1
// status fields
`define WCC_ST_NEG        0
`define WCC_ST_ZERO       1
`define WCC_ST_POWERDOWN  2
`define WCC_ST_TIMEOUT    3

// reset values
`define WCC_CTRL_RST      2'h0
`define WCC_BANK_RST      4'h0
`define WCC_WORK_RST      8'h00
`define WCC_INDEX_RST     12'h000
`define WCC_FLAG_RST      1'b1

// addressing
`define WCC_ACCESS_LIMIT  8'h5f
`define WCC_SFR_PAGE      4'hf
`define WCC_LOW_PAGE      4'h0

// timing: phases per instruction cycle
`define WCC_Q_PHASES      4

`endif

/* wcc_pkg.sv */
// types shared by the execution block and its phase sequencer
// assumes the constants header is compiled alongside
package wcc_pkg;

   // instruction kinds handed over by the decode stage
   typedef enum logic [1:0] {
      WCC_OP_NONE,
      WCC_OP_CLEAR_WATCHDOG,
      WCC_OP_COMPLEMENT_FILE
   } wcc_op_t;

   // one decoded instruction word
   typedef struct packed {
      wcc_op_t    op;
      logic [7:0] fileAddr;
      logic       dest;
      logic       access;
   } wcc_instr_t;

   // flags of the status register
   typedef struct packed {
      logic timeoutFlag;
      logic powerdownFlag;
      logic zero;
      logic negative;
   } wcc_status_t;

endpackage : wcc_pkg

/* wcc_qphase.sv */
// four-phase instruction cycle sequencer
// assumes a free-running system clock; phases are one-cycle enables
`timescale 1ns/1ns
`default_nettype none
`include "wcc_cfg.svh"

module wcc_qphase #(
   parameter int PHASES = `WCC_Q_PHASES
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   output logic [PHASES-1:0]      qPhase
);
   import wcc_pkg::*;

   // one-hot ring, phase one first after reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         qPhase <= PHASES'(1);
      end else begin
         qPhase <= {qPhase[PHASES-2:0], qPhase[PHASES-1]};
      end
   end

endmodule : wcc_qphase
`default_nettype wire

/* wcc_exec.sv */
// execution of clear-watchdog and complement-file instructions
// assumes decode and data memory on sys_clk, memory read data combinational
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "wcc_cfg.svh"

module wcc_exec #(
   parameter int CNT_WIDTH  = 8,
   parameter int POST_WIDTH = 4
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              instrValid,
   input  wire wcc_pkg::wcc_instr_t instrIn,
   output logic                   instrDone,
   output logic [11:0]            memAddr,
   output logic                   memRdEn,
   input  wire logic [7:0]        memRdData,
   output logic                   memWrEn,
   output logic [7:0]             memWrData,
   output wcc_pkg::wcc_status_t   statusOut,
   output logic [7:0]             workOut
);
   import wcc_pkg::*;

   logic [3:0]            qPhase;
   wcc_instr_t            instr_reg;
   logic                  active_reg;
   logic [1:0]            ctrl_reg;
   logic [3:0]            bank_reg;
   logic [11:0]           index_reg;
   logic [7:0]            work_reg;
   wcc_status_t           status_reg;
   logic [7:0]            result_reg;
   logic [CNT_WIDTH-1:0]  watchdogCnt_reg;
   logic [POST_WIDTH-1:0] post_reg;
   logic [11:0]           memAddr_reg;
   logic                  memRdEn_reg;
   logic                  memWrEn_reg;
   logic [7:0]            memWrData_reg;
   logic                  done_reg;
   logic [31:0]           prdata_reg;
   logic                  pready_reg;
   logic                  pslverr_reg;
   logic [11:0]           addr_next;
   logic [31:0]           rd_next;
   logic                  hit_next;
   logic                  apbWr;
   logic                  apbAcc;
   logic                  clearWatchdog;
   logic                  isComp;
   logic                  watchdogWrap;

   // phase sequencer
   wcc_qphase #(.PHASES(`WCC_Q_PHASES)) u_qphase (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .qPhase  (qPhase)
   );

   assign isComp   = active_reg && instr_reg.op == WCC_OP_COMPLEMENT_FILE;
   assign clearWatchdog = active_reg && qPhase[2]
                          && instr_reg.op == WCC_OP_CLEAR_WATCHDOG;
   assign watchdogWrap  = ctrl_reg[`WCC_CTRL_RUN] && (&watchdogCnt_reg)
                          && qPhase[3];

   // decode: latch the instruction at phase one
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         active_reg <= 1'b0;
         instr_reg  <= '0;
      end else if (qPhase[0]) begin
         active_reg <= instrValid && instrIn.op != WCC_OP_NONE;
         instr_reg  <= instrIn;
      end
   end

   // file address formation
   always_comb begin
      if (!instr_reg.access && ctrl_reg[`WCC_CTRL_EXT]
          && instr_reg.fileAddr <= `WCC_ACCESS_LIMIT) begin
         addr_next = 12'(index_reg + {4'h0, instr_reg.fileAddr});
      end else if (instr_reg.access) begin
         addr_next = {bank_reg, instr_reg.fileAddr};
      end else if (instr_reg.fileAddr <= `WCC_ACCESS_LIMIT) begin
         addr_next = {`WCC_LOW_PAGE, instr_reg.fileAddr};
      end else begin
         addr_next = {`WCC_SFR_PAGE, instr_reg.fileAddr};
      end
   end

   // memory port: address at phase two, write at phase four
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         memAddr_reg   <= '0;
         memRdEn_reg   <= 1'b0;
         memWrEn_reg   <= 1'b0;
         memWrData_reg <= '0;
      end else begin
         memRdEn_reg <= 1'b0;
         memWrEn_reg <= 1'b0;
         if (qPhase[1] && isComp) begin
            memAddr_reg <= addr_next;
            memRdEn_reg <= 1'b1;
         end
         if (qPhase[3] && isComp && instr_reg.dest) begin
            memWrEn_reg   <= 1'b1;
            memWrData_reg <= result_reg;
         end
      end
   end

   // process: complement the read value at phase three
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         result_reg <= '0;
      end else if (qPhase[2] && isComp) begin
         result_reg <= ~memRdData;
      end
   end

   // working register: instruction result wins over software
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         work_reg <= `WCC_WORK_RST;
      end else if (qPhase[3] && isComp && !instr_reg.dest) begin
         work_reg <= result_reg;
      end else if (apbWr && paddr == `WCC_OFS_WORK) begin
         work_reg <= pwdata[7:0];
      end
   end

   // status flags
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         status_reg.negative      <= 1'b0;
         status_reg.zero          <= 1'b0;
         status_reg.powerdownFlag <= `WCC_FLAG_RST;
         status_reg.timeoutFlag   <= `WCC_FLAG_RST;
      end else begin
         if (qPhase[3] && isComp) begin
            status_reg.negative <= result_reg[7];
            status_reg.zero     <= result_reg == 8'h00;
         end
         if (clearWatchdog) begin
            status_reg.timeoutFlag   <= 1'b1;
            status_reg.powerdownFlag <= 1'b1;
         end else if (watchdogWrap && (&post_reg)) begin
            status_reg.timeoutFlag <= 1'b0; // timeout reached
         end
      end
   end

   // watchdog counter steps once per instruction cycle, postscaler once per counter wrap
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         watchdogCnt_reg <= '0;
         post_reg        <= '0;
      end else if (clearWatchdog) begin
         watchdogCnt_reg <= '0;
         post_reg        <= '0;
      end else if (ctrl_reg[`WCC_CTRL_RUN] && qPhase[3]) begin
         watchdogCnt_reg <= watchdogCnt_reg + 1'b1;
         if (watchdogWrap) begin
            post_reg <= post_reg + 1'b1;
         end
      end
   end

   // completion pulse one edge after phase four
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= qPhase[3] && active_reg;
      end
   end

   // apb handshake: one wait state
   assign apbAcc = psel && penable && pready_reg;
   assign apbWr  = apbAcc && pwrite;

   // software registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_reg  <= `WCC_CTRL_RST;
         bank_reg  <= `WCC_BANK_RST;
         index_reg <= `WCC_INDEX_RST;
      end else if (apbWr) begin
         if (paddr == `WCC_OFS_CTRL) begin
            ctrl_reg <= pwdata[1:0];
         end else if (paddr == `WCC_OFS_BANK) begin
            bank_reg <= pwdata[3:0];
         end else if (paddr == `WCC_OFS_INDEX) begin
            index_reg <= pwdata[11:0];
         end
      end
   end

   // read decode
   always_comb begin
      rd_next  = 32'h0000_0000;
      hit_next = 1'b1;
      if (paddr == `WCC_OFS_CTRL) begin
         rd_next[1:0] = ctrl_reg;
      end else if (paddr == `WCC_OFS_BANK) begin
         rd_next[3:0] = bank_reg;
      end else if (paddr == `WCC_OFS_WORK) begin
         rd_next[7:0] = work_reg;
      end else if (paddr == `WCC_OFS_STATUS) begin
         rd_next[`WCC_ST_NEG]  = status_reg.negative;
         rd_next[`WCC_ST_ZERO] = status_reg.zero;
         rd_next[`WCC_ST_POWERDOWN] = status_reg.powerdownFlag;
         rd_next[`WCC_ST_TIMEOUT]   = status_reg.timeoutFlag;
      end else if (paddr == `WCC_OFS_WATCHDOG) begin
         rd_next[CNT_WIDTH-1:0]        = watchdogCnt_reg;
         rd_next[16+POST_WIDTH-1:16]   = post_reg;
      end else if (paddr == `WCC_OFS_INDEX) begin
         rd_next[11:0] = index_reg;
      end else begin
         hit_next = 1'b0;
      end
   end

   // apb answer registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= psel && penable && !pready_reg;
         pslverr_reg <= psel && penable && !pready_reg && !hit_next;
         if (psel && penable && !pready_reg && !pwrite) begin
            prdata_reg <= rd_next;
         end
      end
   end

   assign prdata    = prdata_reg;
   assign pready    = pready_reg;
   assign pslverr   = pslverr_reg;
   assign instrDone = done_reg;
   assign memAddr   = memAddr_reg;
   assign memRdEn   = memRdEn_reg;
   assign memWrEn   = memWrEn_reg;
   assign memWrData = memWrData_reg;
   assign statusOut = status_reg;
   assign workOut   = work_reg;

   // counter is zero after a clear-watchdog
   a_counter_cleared: assert property (@(posedge sys_clk)
      disable iff (!rst_n) clearWatchdog |=> watchdogCnt_reg == '0)
      else $error("watchdog counter not cleared");

   // postscaler is zero after a clear-watchdog
   a_post_cleared: assert property (@(posedge sys_clk)
      disable iff (!rst_n) clearWatchdog |=> post_reg == '0)
      else $error("postscaler not cleared");

   // both flags set, result flags untouched
   a_flags_set: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      clearWatchdog |=> status_reg.timeoutFlag && status_reg.powerdownFlag
         && $stable(status_reg.zero) && $stable(status_reg.negative))
      else $error("clear-watchdog flag update wrong");

   // complemented value lands in file or working register
   a_comp_result: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (qPhase[2] && isComp) ##1 qPhase[3]
      |=> (instr_reg.dest ? (memWrEn_reg && memWrData_reg == result_reg)
          : (work_reg == result_reg && !memWrEn_reg))
          && result_reg == ~$past(memRdData, 2)
          && status_reg.negative == result_reg[7]
          && status_reg.zero == (result_reg == 8'h00))
      else $error("complement result misplaced");

   // banked access uses the bank select register
   a_bank_addr: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (qPhase[1] && isComp && instr_reg.access)
      |=> memAddr_reg == {$past(bank_reg), $past(instr_reg.fileAddr)})
      else $error("banked address wrong");

   // indexed literal offset address
   a_indexed_addr: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (qPhase[1] && isComp && !instr_reg.access && ctrl_reg[`WCC_CTRL_EXT]
         && instr_reg.fileAddr <= `WCC_ACCESS_LIMIT)
      |=> memAddr_reg == 12'($past(index_reg)
          + {4'h0, $past(instr_reg.fileAddr)}))
      else $error("indexed address wrong");

   // an accepted instruction completes in one instruction cycle
   a_one_cycle: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      (qPhase[0] && instrValid && instrIn.op != WCC_OP_NONE)
      |=> !instrDone ##3 instrDone ##1 !instrDone)
      else $error("instruction cycle length wrong");

endmodule : wcc_exec
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the watchdog-clear and complement block
// assumes the design files and the constants header are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "wcc_cfg.svh"

module tb_top;
   import wcc_pkg::*;

   logic        sys_clk     = 1'b0;
   logic        rst_n       = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic [31:0] pwdata      = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        instrValid  = 1'b0;
   wcc_instr_t  instrIn     = '0;
   logic        instrDone;
   logic [11:0] memAddr;
   logic        memRdEn;
   logic [7:0]  memRdData;
   logic        memWrEn;
   logic [7:0]  memWrData;
   wcc_status_t statusOut;
   logic [7:0]  workOut;
   logic [7:0]  memArr [0:4095];
   logic [31:0] rdData;
   logic        rdErr;
   int          edgeCnt     = 0;
   int          miscompares = 0;
   int          totalChecks = 0;

   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   wcc_exec u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .instrValid(instrValid),
      .instrIn(instrIn), .instrDone(instrDone), .memAddr(memAddr),
      .memRdEn(memRdEn), .memRdData(memRdData), .memWrEn(memWrEn),
      .memWrData(memWrData), .statusOut(statusOut), .workOut(workOut)
   );

   // edges since reset release; index 0 mod 4 is a decode edge
   always @(posedge sys_clk) begin
      edgeCnt <= rst_n ? edgeCnt + 1 : 0;
   end

   // data memory with combinational read
   assign memRdData = memArr[memAddr];
   always @(posedge sys_clk) begin
      if (memWrEn === 1'b1) memArr[memAddr] <= memWrData;
   end

   task automatic tallyAndFinish;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tallyAndFinish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // wait for the answer; the wait ends when pready is high, the hang guard ends the run if it never is
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdData = prdata;
      rdErr  = pslverr;
      chk(32'(pready), 32'h1, "apb answer");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // issue at a decode edge, follow the phases, stop in the done cycle
   task automatic exec(input wcc_op_t op, input logic [7:0] f,
                       input logic d, input logic a);
      @(posedge sys_clk);
      while (edgeCnt % 4 != 3) @(posedge sys_clk);
      instrValid <= 1'b1;
      instrIn    <= '{op: op, fileAddr: f, dest: d, access: a};
      @(posedge sys_clk);
      instrValid <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(32'(memRdEn), 32'(op == WCC_OP_COMPLEMENT_FILE), "rd strobe");
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(32'(instrDone), 32'h0, "done early");
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(32'(instrDone), 32'h1, "done");
   endtask : exec

   // complement of v stored at ea, checked at its destination
   task automatic compFile(input logic [7:0] f, input logic d, input logic a,
                           input logic [11:0] ea, input logic [7:0] v);
      logic [7:0] r;
      r = ~v;
      memArr[ea] = v;
      exec(WCC_OP_COMPLEMENT_FILE, f, d, a);
      chk(32'(memAddr), 32'(ea), "address");
      chk(32'(memWrEn), 32'(d), "write strobe");
      if (d) chk(32'(memWrData), 32'(r), "file result");
      else chk(32'(workOut), 32'(r), "work result");
      chk(32'({statusOut.zero, statusOut.negative}),
          32'({r == 8'h00, r[7]}), "n z flags");
   endtask : compFile

   initial begin
      int n;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      chk(32'(statusOut), 32'hc, "reset flags");
      apb(1'b1, `WCC_OFS_STATUS, 32'h0);
      apb(1'b0, `WCC_OFS_STATUS, 32'h0);
      chk(rdData, 32'hc, "status read only");
      apb(1'b0, 12'h020, 32'h0);
      chk(32'(rdErr), 32'h1, "unmapped error");
      chk(rdData, 32'h0, "unmapped data");
      apb(1'b1, `WCC_OFS_BANK, 32'h3);
      compFile(8'h13, 1'b0, 1'b1, 12'h313, 8'h13);
      apb(1'b0, `WCC_OFS_WORK, 32'h0);
      chk(rdData, 32'hec, "work read");
      compFile(8'h20, 1'b1, 1'b0, 12'h020, 8'hff);
      @(negedge sys_clk);
      chk(32'(memArr[12'h020]), 32'h0, "stored back");
      compFile(8'h80, 1'b0, 1'b0, 12'hf80, 8'h5a);
      apb(1'b1, `WCC_OFS_CTRL, 32'h1);
      apb(1'b1, `WCC_OFS_INDEX, 32'h1f0);
      compFile(8'h44, 1'b1, 1'b1, 12'h344, 8'h80);
      compFile(8'h5f, 1'b0, 1'b0, 12'h24f, 8'h0f);
      compFile(8'h60, 1'b0, 1'b0, 12'hf60, 8'h00);
      // let the watchdog run out so the timeout flag drops
      apb(1'b1, `WCC_OFS_CTRL, 32'h2);
      n = 0;
      while (statusOut.timeoutFlag !== 1'b0 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(statusOut.timeoutFlag), 32'h0, "timeout dropped");
      repeat (20) @(posedge sys_clk);
      apb(1'b1, `WCC_OFS_CTRL, 32'h0);
      apb(1'b0, `WCC_OFS_WATCHDOG, 32'h0);
      chk(32'(rdData[7:0] != 8'h00), 32'h1, "counter running");
      exec(WCC_OP_CLEAR_WATCHDOG, 8'h00, 1'b0, 1'b0);
      chk(32'(statusOut), 32'hd, "flags after clear");
      chk(32'(memWrEn), 32'h0, "no file write");
      apb(1'b0, `WCC_OFS_WATCHDOG, 32'h0);
      chk(rdData & 32'h0000_00ff, 32'h0, "counter zero");
      chk(rdData & 32'h000f_0000, 32'h0, "postscaler zero");
      tallyAndFinish();
   end

   // hang guard
   initial begin
      repeat (40000) @(posedge sys_clk);
      miscompares++;
      $display("[ERR] %0t run did not finish", $time);
      tallyAndFinish();
   end

endmodule : tb_top

`default_nettype wire
